// ===== pkg/epc_consts.vh
// Constants for the receive payload conditioning block: register indexes,
// field positions, reset values and the indirect access timing.
// Assumes a 100 MHz ref_clk and AHB-Lite word addressing (byte address = 4 x index).
`ifndef EPC_CONSTS_VH
`define EPC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define EPC_IDX_RX_CFG        7'h5C
`define EPC_IDX_RX_STAT       7'h5D
`define EPC_IDX_RX_ADDR_CTRL  7'h5E
`define EPC_IDX_RX_DATA_BUF   7'h5F
`define EPC_IDX_TX_CFG        7'h60
`define EPC_IDX_TX_STAT       7'h61
`define EPC_IDX_TX_ADDR_CTRL  7'h62
`define EPC_IDX_TEST_CTRL     7'h70

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EPC_CFG_ENABLE_BIT    0
`define EPC_STAT_BUSY_BIT     7
`define EPC_AC_RNW_BIT        7
`define EPC_TST_PATDIR_BIT    0
`define EPC_TST_FRAC_BIT      1
`define EPC_SLOT_TEST_BIT     7
`define EPC_SLOT_DTRK_BIT     6
`define EPC_SLOT_STRK_BIT     5
`define EPC_SLOT_MW_BIT       4
`define EPC_SLOT_LAW_BIT      3
`define EPC_SLOT_SINV_BIT     2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define EPC_RST_BYTE          8'h00
`define EPC_RST_TEST_CTRL     8'h00

// ----------------------------------------------------------------------------
// Indirect space
// ----------------------------------------------------------------------------
`define EPC_IND_CFG_BASE      7'h20
`define EPC_IND_TRK_BASE      7'h40
`define EPC_IND_SIG_BASE      7'h60

// ----------------------------------------------------------------------------
// Timing: indirect operation cycle
// ----------------------------------------------------------------------------
`define EPC_CLK_PERIOD_NS     10
`define EPC_IND_OP_NS         490
`define EPC_IND_OP_CYCLES     ((`EPC_IND_OP_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)

`endif

// ===== hw/epc_rx_payload_ctrl.v
// Receive payload per-slot conditioning with indirect register port, AHB-Lite slave.
// Assumes the framer supplies slot number, bit index and line bits on ref_clk,
// one bit per rx_bit_valid pulse, bit index 0 being slot bit 1 (the MSB).
// Summary of operation
// - Read request places the addressed indirect byte in the buffer after 490 ns.
// - Writing address/control while not busy starts an internal access with the new address and direction; a write while busy is dropped.
// - Bit 7 picks read (1) or write (0); low seven bits address 20H..7FH.
// - Busy reads 1 during an access and clears on a clock edge after 490 ns.
// - 20H-3FH slot config, 40H-5FH data trunk codes, 61H-7FH signaling nibbles.
// - Test bit with select 0 extracts slot data; select 1 inserts generated pattern.
// - Extracted slots form one stream; inserted slots draw consecutively from one pattern.
// - Data trunk bit set sends the slot's trunk code, MSB first, on serial data.
// - In slave fractional mode the data trunk bit gates that slot's clock.
// - Signaling trunk bit set sends the stored nibble on the signaling pin.
// - Milliwatt bit substitutes the milliwatt pattern; law select 0 mu-law, 1 A-law.
// - Sign-invert 0: select inverts none, even bits, odd bits or all.
// - Sign-invert 1: select inverts bit 1, bits 1,2,4,6,8, bits 3,5,7, or all but 1.
// - Precedence: extraction, data trunk, milliwatt, generated pattern, then inversion.
// - Transmit configuration bit 0 enables transmit per-slot functions, default 0.
// - Receive configuration bit 0 enables receive per-slot functions.
//
// The implementer's own choice: the AHB-Lite slave port.
`include "epc_consts.vh"

module epc_rx_payload_ctrl #(
  parameter SLOTS = 32
) (
  input  wire        ref_clk,
  input  wire        resetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Receive stream from the framer (same clock domain)
  input  wire        rx_bit_valid,
  input  wire [4:0]  rx_slot,
  input  wire [2:0]  rx_bit_idx,
  input  wire        rx_line_data,
  input  wire        rx_line_sig,
  // Pattern generator/detector
  output reg         pattern_gen_detector_extract_valid,
  output reg         pattern_gen_detector_extract_bit,
  output wire        pattern_gen_detector_gen_take,
  input  wire        pattern_gen_detector_gen_bit,
  // Outputs towards the backplane
  output reg         receive_serial_data,
  output reg         receive_signaling_out,
  output reg         receive_slot_clock,
  output wire        tx_per_slot_enable,
  output wire        tx_indirect_start
);

  // --------------------------------------------------------------------------
  // Registers and storage
  // --------------------------------------------------------------------------
  // Count kept 32 bits wide first, then cut to the counter width on purpose
  localparam [31:0] OP_CYCLES_W = `EPC_IND_OP_CYCLES;
  localparam [6:0]  OP_CYCLES   = OP_CYCLES_W[6:0];

  reg  [7:0] slot_cfg_mem  [0:SLOTS-1];
  reg  [7:0] trunk_mem     [0:SLOTS-1];
  reg  [3:0] sig_mem       [0:SLOTS-1];

  reg  [7:0] rx_cfg_q;
  reg  [7:0] rx_addr_ctrl_q;
  reg  [7:0] rx_data_buf_q;
  reg        rx_busy_q;
  reg  [6:0] rx_cnt_q;
  reg  [7:0] tx_cfg_q;
  reg  [7:0] tx_addr_ctrl_q;
  reg        tx_busy_q;
  reg  [6:0] tx_cnt_q;
  reg  [7:0] test_ctrl_q;
  reg  [2:0] mw_phase_q;

  // AHB data phase state
  reg        dp_wr_q;
  reg        dp_rd_q;
  reg        rd_wait_q;
  reg  [6:0] dp_idx_q;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Inversion mask indexed by serial bit position (index 0 is slot bit 1)
  function [7:0] inv_mask;
    input       sinv;
    input [1:0] sel;
    begin
      case ({sinv, sel})
        3'b000:  inv_mask = 8'h00;
        3'b001:  inv_mask = 8'hAA;
        3'b010:  inv_mask = 8'h55;
        3'b011:  inv_mask = 8'hFF;
        3'b100:  inv_mask = 8'h01;
        3'b101:  inv_mask = 8'hAB;
        3'b110:  inv_mask = 8'h54;
        default: inv_mask = 8'hFE;
      endcase
    end
  endfunction

  // One byte of the eight-frame milliwatt sequence
  function [7:0] mw_byte;
    input       alaw;
    input [2:0] ph;
    begin
      case (ph)
        3'd0, 3'd3: mw_byte = alaw ? 8'h34 : 8'h1E;
        3'd1, 3'd2: mw_byte = alaw ? 8'h21 : 8'h0B;
        3'd4, 3'd7: mw_byte = alaw ? 8'hB4 : 8'h9E;
        default:    mw_byte = alaw ? 8'hA1 : 8'h8B;
      endcase
    end
  endfunction

  // Indirect read mux; reserved bits and holes read zero
  function [7:0] ind_read;
    input [6:0] a;
    begin
      if (a >= `EPC_IND_CFG_BASE && a < `EPC_IND_TRK_BASE)
        ind_read = slot_cfg_mem[a[4:0]];
      else if (a >= `EPC_IND_TRK_BASE && a < `EPC_IND_SIG_BASE)
        ind_read = trunk_mem[a[4:0]];
      else if (a > `EPC_IND_SIG_BASE)
        ind_read = {4'h0, sig_mem[a[4:0]]};
      else
        ind_read = 8'h00;
    end
  endfunction

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  // Reads take one wait state so that hrdata comes from a flop and still
  // reflects a write made in the cycle before.
  wire       acc      = hsel & htrans[1] & hready;
  wire       wr_rxac  = dp_wr_q & (dp_idx_q == `EPC_IDX_RX_ADDR_CTRL);
  wire       wr_txac  = dp_wr_q & (dp_idx_q == `EPC_IDX_TX_ADDR_CTRL);
  wire       rx_start = wr_rxac & ~rx_busy_q;
  wire       tx_start = wr_txac & ~tx_busy_q;
  wire       rx_done  = rx_busy_q & (rx_cnt_q == 7'd0);
  wire [6:0] rx_iaddr = rx_addr_ctrl_q[6:0];
  wire       rx_rnw   = rx_addr_ctrl_q[`EPC_AC_RNW_BIT];

  assign hreadyout = ~(dp_rd_q & ~rd_wait_q);
  assign hresp     = 1'b0;

  // Address phase capture
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      rd_wait_q <= 1'b0;
      dp_idx_q  <= 7'h00;
    end else begin
      if (hreadyout) begin
        dp_wr_q  <= acc & hwrite;
        dp_rd_q  <= acc & ~hwrite;
        dp_idx_q <= haddr[8:2];
      end
      rd_wait_q <= dp_rd_q & ~rd_wait_q;
    end
  end

  // Read data, loaded during the wait state
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (dp_rd_q & ~rd_wait_q) begin
      case (dp_idx_q)
        `EPC_IDX_RX_CFG:       hrdata <= {24'h000000, rx_cfg_q};
        `EPC_IDX_RX_STAT:      hrdata <= {24'h000000, rx_busy_q, 7'h00};
        `EPC_IDX_RX_ADDR_CTRL: hrdata <= {24'h000000, rx_addr_ctrl_q};
        `EPC_IDX_RX_DATA_BUF:  hrdata <= {24'h000000, rx_data_buf_q};
        `EPC_IDX_TX_CFG:       hrdata <= {24'h000000, tx_cfg_q};
        `EPC_IDX_TX_STAT:      hrdata <= {24'h000000, tx_busy_q, 7'h00};
        `EPC_IDX_TX_ADDR_CTRL: hrdata <= {24'h000000, tx_addr_ctrl_q};
        `EPC_IDX_TEST_CTRL:    hrdata <= {24'h000000, test_ctrl_q};
        default:               hrdata <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Direct registers
  // --------------------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_cfg_q       <= `EPC_RST_BYTE;
      tx_cfg_q       <= `EPC_RST_BYTE;
      test_ctrl_q    <= `EPC_RST_TEST_CTRL;
      rx_addr_ctrl_q <= `EPC_RST_BYTE;
      tx_addr_ctrl_q <= `EPC_RST_BYTE;
    end else begin
      if (dp_wr_q & (dp_idx_q == `EPC_IDX_RX_CFG))
        rx_cfg_q <= {7'h00, hwdata[0]};
      if (dp_wr_q & (dp_idx_q == `EPC_IDX_TX_CFG))
        tx_cfg_q <= {7'h00, hwdata[0]};
      if (dp_wr_q & (dp_idx_q == `EPC_IDX_TEST_CTRL))
        test_ctrl_q <= {6'h00, hwdata[1:0]};
      if (rx_start)
        rx_addr_ctrl_q <= hwdata[7:0];
      if (tx_start)
        tx_addr_ctrl_q <= hwdata[7:0];
    end
  end

  assign tx_per_slot_enable = tx_cfg_q[`EPC_CFG_ENABLE_BIT];
  assign tx_indirect_start  = tx_start;

  // --------------------------------------------------------------------------
  // Indirect access engines
  // --------------------------------------------------------------------------
  // Busy spans OP_CYCLES edges; the access itself lands on the final edge.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 7'h00;
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 7'h00;
    end else begin
      if (rx_start) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= OP_CYCLES - 7'd1;
      end else if (rx_done) begin
        rx_busy_q <= 1'b0;
      end else if (rx_busy_q) begin
        rx_cnt_q  <= rx_cnt_q - 7'd1;
      end
      if (tx_start) begin
        tx_busy_q <= 1'b1;
        tx_cnt_q  <= OP_CYCLES - 7'd1;
      end else if (tx_busy_q & (tx_cnt_q == 7'd0)) begin
        tx_busy_q <= 1'b0;
      end else if (tx_busy_q) begin
        tx_cnt_q  <= tx_cnt_q - 7'd1;
      end
    end
  end

  // Data buffer; the completing read beats a bus write in the same cycle
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_buf_q <= `EPC_RST_BYTE;
    end else if (rx_done & rx_rnw) begin
      rx_data_buf_q <= ind_read(rx_iaddr);
    end else if (dp_wr_q & (dp_idx_q == `EPC_IDX_RX_DATA_BUF)) begin
      rx_data_buf_q <= hwdata[7:0];
    end
  end

  // Indirect storage; contents are undefined until written
  always @(posedge ref_clk) begin
    if (rx_done & ~rx_rnw) begin
      if (rx_iaddr >= `EPC_IND_CFG_BASE && rx_iaddr < `EPC_IND_TRK_BASE)
        slot_cfg_mem[rx_iaddr[4:0]] <= rx_data_buf_q;
      else if (rx_iaddr >= `EPC_IND_TRK_BASE && rx_iaddr < `EPC_IND_SIG_BASE)
        trunk_mem[rx_iaddr[4:0]] <= rx_data_buf_q;
      else if (rx_iaddr > `EPC_IND_SIG_BASE)
        sig_mem[rx_iaddr[4:0]] <= rx_data_buf_q[3:0];
    end
  end

  // --------------------------------------------------------------------------
  // Per-slot datapath
  // --------------------------------------------------------------------------
  wire       per_slot_function_enable    = rx_cfg_q[`EPC_CFG_ENABLE_BIT];
  wire [7:0] cfg     = slot_cfg_mem[rx_slot];
  wire [7:0] trk     = trunk_mem[rx_slot];
  wire [3:0] sig     = sig_mem[rx_slot];
  wire       patdir  = test_ctrl_q[`EPC_TST_PATDIR_BIT];
  wire       frac    = test_ctrl_q[`EPC_TST_FRAC_BIT];
  wire       s_test  = per_slot_function_enable & cfg[`EPC_SLOT_TEST_BIT];
  wire       s_dtrk  = per_slot_function_enable & cfg[`EPC_SLOT_DTRK_BIT];
  wire       s_strk  = per_slot_function_enable & cfg[`EPC_SLOT_STRK_BIT];
  wire       s_mw    = per_slot_function_enable & cfg[`EPC_SLOT_MW_BIT];
  wire       s_extr  = s_test & ~patdir;
  wire       s_gen   = s_test & patdir;
  wire [7:0] mw      = mw_byte(cfg[`EPC_SLOT_LAW_BIT], mw_phase_q);
  wire [7:0] mask    = inv_mask(cfg[`EPC_SLOT_SINV_BIT], cfg[1:0]);
  wire [2:0] msb_pos = 3'd7 - rx_bit_idx;
  wire       use_gen = s_gen & ~s_dtrk & ~s_mw;

  // Only slots that really take the pattern advance it, keeping it contiguous
  assign pattern_gen_detector_gen_take = rx_bit_valid & use_gen;

  // Output bit selection in priority order
  reg out_bit;
  always @* begin
    out_bit = rx_line_data;
    if (s_extr)
      out_bit = rx_line_data;
    else if (s_dtrk)
      out_bit = trk[msb_pos];
    else if (s_mw)
      out_bit = mw[msb_pos];
    else if (s_gen)
      out_bit = pattern_gen_detector_gen_bit;
    else if (per_slot_function_enable)
      out_bit = rx_line_data ^ mask[rx_bit_idx];
  end

  // Registered backplane outputs, one cycle behind each bit strobe
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      receive_serial_data   <= 1'b0;
      receive_signaling_out <= 1'b0;
      receive_slot_clock    <= 1'b0;
      pattern_gen_detector_extract_valid    <= 1'b0;
      pattern_gen_detector_extract_bit      <= 1'b0;
      mw_phase_q            <= 3'd0;
    end else begin
      receive_slot_clock <= rx_bit_valid & ~(frac & s_dtrk);
      pattern_gen_detector_extract_valid <= rx_bit_valid & s_extr;
      if (rx_bit_valid) begin
        receive_serial_data   <= out_bit;
        receive_signaling_out <= s_strk ? sig[3 - rx_bit_idx[1:0]] : rx_line_sig;
        pattern_gen_detector_extract_bit      <= rx_line_data;
        if (rx_slot == 5'd31 && rx_bit_idx == 3'd7)
          mw_phase_q <= mw_phase_q + 3'd1;
      end
    end
  end

endmodule // epc_rx_payload_ctrl

// ===== dv/epc_rx_payload_ctrl_assertions.sv
// Checker bound to the receive payload block: bus handshake and stream timing.
// Assumes one clock domain and hready fed back from hreadyout.
`include "epc_consts.vh"
module epc_rx_payload_ctrl_assertions (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rx_bit_valid,
  input wire logic        rx_line_data,
  input wire logic        pattern_gen_detector_extract_valid,
  input wire logic        pattern_gen_detector_extract_bit,
  input wire logic        pattern_gen_detector_gen_take,
  input wire logic        receive_slot_clock,
  input wire logic        tx_indirect_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------------------
  // Helper state
  // --------------------------------------------------------------------------
  logic       dp_q;
  logic       wr_q;
  logic [6:0] idx_q;
  logic [5:0] txc_q;
  wire        req = hsel && htrans[1] && hready;
  wire        tx_wr = dp_q && wr_q && idx_q == `EPC_IDX_TX_ADDR_CTRL && txc_q == 6'h00;
  // Data phase tracker, and a copy of the transmit busy window
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dp_q  <= 1'b0;
      wr_q  <= 1'b0;
      idx_q <= 7'h00;
      txc_q <= 6'h00;
    end else begin
      if (hready) begin
        dp_q  <= req;
        wr_q  <= hwrite;
        idx_q <= haddr[8:2];
      end
      if (tx_indirect_start && hready)
        txc_q <= 6'(`EPC_IND_OP_CYCLES);
      else if (txc_q != 6'h00)
        txc_q <= txc_q - 6'h01;
    end
  end
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("slave gave an error response");
  chk_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  chk_write_nowait: assert property (req && hwrite |=> hreadyout)
    else $error("write data phase stretched");
  chk_rdata_upper: assert property (dp_q && !wr_q && hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  chk_tx_start: assert property (tx_wr |-> tx_indirect_start)
    else $error("accepted transmit command did not start");
  chk_tx_busy: assert property (tx_indirect_start |-> tx_wr)
    else $error("transmit access started while busy");
  chk_clk_cause: assert property (receive_slot_clock |-> $past(rx_bit_valid))
    else $error("slot clock without a line bit");
  chk_extract_bit: assert property (pattern_gen_detector_extract_valid |-> pattern_gen_detector_extract_bit == $past(rx_line_data))
    else $error("extracted bit differs from line bit");
  chk_gen_excl: assert property (pattern_gen_detector_gen_take |-> rx_bit_valid ##1 !pattern_gen_detector_extract_valid)
    else $error("pattern taken outside a bit or also extracted");
endmodule // epc_rx_payload_ctrl_assertions

bind epc_rx_payload_ctrl epc_rx_payload_ctrl_assertions u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .rx_bit_valid(rx_bit_valid), .rx_line_data(rx_line_data), .pattern_gen_detector_extract_valid(pattern_gen_detector_extract_valid),
  .pattern_gen_detector_extract_bit(pattern_gen_detector_extract_bit), .pattern_gen_detector_gen_take(pattern_gen_detector_gen_take),
  .receive_slot_clock(receive_slot_clock), .tx_indirect_start(tx_indirect_start));

// ===== dv/epc_framer_model.sv
// Framer and pattern source model feeding the receive payload block.
// Assumes the same ref_clk; slow inserts an idle cycle after every bit.
module epc_framer_model (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic       slow,
  input  wire logic       pattern_gen_detector_gen_take,
  output logic            rx_bit_valid,
  output logic [4:0]      rx_slot,
  output logic [2:0]      rx_bit_idx,
  output logic            rx_line_data,
  output logic            rx_line_sig,
  output logic            pattern_gen_detector_gen_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  n_q;
  logic [15:0] lf_q;
  logic [6:0]  pr_q;
  // Outside a bit the lines show the inverse, so stale values never pass
  assign rx_slot      = n_q[7:3];
  assign rx_bit_idx   = n_q[2:0];
  assign rx_line_data = rx_bit_valid ? lf_q[0] : ~lf_q[0];
  assign rx_line_sig  = rx_bit_valid ? lf_q[1] : ~lf_q[1];
  assign pattern_gen_detector_gen_bit = pr_q[6];
  // Bit sequencing; the pattern only moves when a bit is taken
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_bit_valid <= 1'b0;
      n_q          <= 8'h00;
      lf_q         <= 16'hACE1;
      pr_q         <= 7'h7F;
    end else begin
      rx_bit_valid <= run & ~(slow & rx_bit_valid);
      if (rx_bit_valid) begin
        n_q  <= n_q + 8'h01;
        lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
      end
      if (pattern_gen_detector_gen_take)
        pr_q <= {pr_q[5:0], pr_q[6] ^ pr_q[5]};
    end
  end
endmodule // epc_framer_model

// ===== dv/epc_rx_payload_ctrl_tb.sv
// Testbench: register and indirect access over the bus, then per-slot stream checks.
// Assumes the framer model drives the stream and the checker is bound.
`include "epc_consts.vh"
module epc_rx_payload_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, resetn, hsel, hwrite, run, slow, mon, en_q, pat_q, frac_q;
  logic        pv, pl, pg, psig;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pi;
  logic [4:0]  ps;
  logic [31:0] haddr, hwdata;
  logic [7:0]  cfg [32], trk [32], sig [32], d;
  wire         hreadyout, hresp, vld, line, lsig, gbit, gtake, ext_v, ext_b, sdat, sout, sclk, tx_en;
  wire  [31:0] hrdata;
  wire  [4:0]  slot;
  wire  [2:0]  idx;
  int          bad_count, comparisons;
  realtime     t_cmd;
  logic [3:0]  hi [4] = '{4'h0, 4'h8, 4'hE, 4'h9};
  logic [6:0]  ri [9] = '{7'h5C, 7'h5D, 7'h5E, 7'h5F, 7'h60, 7'h61, 7'h62, 7'h70, 7'h10};

  epc_rx_payload_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_bit_valid(vld), .rx_slot(slot),
    .rx_bit_idx(idx), .rx_line_data(line), .rx_line_sig(lsig), .pattern_gen_detector_extract_valid(ext_v),
    .pattern_gen_detector_extract_bit(ext_b), .pattern_gen_detector_gen_take(gtake), .pattern_gen_detector_gen_bit(gbit), .receive_serial_data(sdat),
    .receive_signaling_out(sout), .receive_slot_clock(sclk), .tx_per_slot_enable(tx_en),
    .tx_indirect_start());
  epc_framer_model u_frm (.ref_clk(ref_clk), .resetn(resetn), .run(run), .slow(slow),
    .pattern_gen_detector_gen_take(gtake), .rx_bit_valid(vld), .rx_slot(slot), .rx_bit_idx(idx),
    .rx_line_data(line), .rx_line_sig(lsig), .pattern_gen_detector_gen_bit(gbit));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One single transfer; hold each phase until hready is seen high
  task automatic bus(input logic w, input logic [6:0] ix, input logic [7:0] wd, output logic [7:0] rv);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    haddr  <= {23'h000000, ix, 2'b00};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rv = hrdata[7:0];
  endtask
  // Operation time is reckoned from the edge at which the command landed
  task automatic idle(input logic [6:0] st_ix, input realtime t0);
    logic [7:0] st;
    bus(1'b0, st_ix, 8'h00, st);
    chk("busy", 8'h80, st);
    while (st !== 8'h00) bus(1'b0, st_ix, 8'h00, st);
    chk("op time", 1, $realtime - t0 >= 490.0 && $realtime - t0 <= 560.0);
  endtask
  task automatic ind(input logic w, input logic [6:0] a, inout logic [7:0] dv);
    logic [7:0] x;
    if (w) bus(1'b1, `EPC_IDX_RX_DATA_BUF, dv, x);
    bus(1'b1, `EPC_IDX_RX_ADDR_CTRL, {~w, a}, x);
    idle(`EPC_IDX_RX_STAT, $realtime);
    if (!w) bus(1'b0, `EPC_IDX_RX_DATA_BUF, 8'h00, dv);
  endtask
  // 600 cycles of stream with the given enable, pattern direction, fractional mode and slow setting
  task automatic phase(input logic e, p, f, sl);
    logic [7:0] x;
    bus(1'b1, `EPC_IDX_TEST_CTRL, {6'h00, f, p}, x);
    bus(1'b1, `EPC_IDX_RX_CFG, {7'h00, e}, x);
    {en_q, pat_q, frac_q} = {e, p, f};
    slow <= sl;
    run  <= 1'b1;
    mon = 1'b1;
    repeat (600) @(posedge ref_clk);
    run <= 1'b0;
    repeat (4) @(posedge ref_clk);
    mon = 1'b0;
  endtask
  // Expected serial bit as {compare, value}; milliwatt slots are not compared
  function automatic logic [1:0] xd(input logic [4:0] s, input logic [2:0] i, input logic l, g);
    logic [7:0] c;
    logic       m;
    c = cfg[s];
    if (!en_q || (c[7] && !pat_q)) return {1'b1, l};
    if (c[6]) return {1'b1, trk[s][3'd7 - i]};
    if (c[4]) return 2'b00;
    if (c[7]) return {1'b1, g};
    case (c[2:0])
      3'b000: m = 1'b0;
      3'b001: m = i[0];
      3'b010: m = !i[0];
      3'b011: m = 1'b1;
      3'b100: m = i == 3'd0;
      3'b101: m = i == 3'd0 || i[0];
      3'b110: m = !i[0] && i != 3'd0;
      default: m = i != 3'd0;
    endcase
    return {1'b1, l ^ m};
  endfunction

  // --------------------------------------------------------------------------
  // Stream monitor, at the falling edge where everything has settled
  // --------------------------------------------------------------------------
  always @(negedge ref_clk) begin
    logic [7:0] c;
    logic [1:0] x;
    c = cfg[ps];
    x = xd(ps, pi, pl, pg);
    if (mon) begin
      chk("slot clock", pv && !(frac_q && en_q && c[6]), sclk);
      chk("extract", pv && en_q && c[7] && !pat_q, ext_v);
      chk("gen take", vld && en_q && pat_q && cfg[slot][7] && !cfg[slot][6] && !cfg[slot][4], gtake);
      if (pv && x[1]) chk("data", x[0], sdat);
      if (pv) chk("sig", (en_q && c[5]) ? sig[ps][2'd3 - pi[1:0]] : psig, sout);
    end
    {pv, ps, pi, pl, pg, psig} = {vld, slot, idx, line, gbit, lsig};
  end

  // --------------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // --------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #400us;
    bad_count++;
    wrap_up();
  end
  initial begin
    {resetn, hsel, hwrite, run, slow, mon, htrans, hsize, haddr, hwdata} = '0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, an unmapped index among them
    foreach (ri[k]) begin
      bus(1'b0, ri[k], 8'h00, d);
      chk("reset value", 8'h00, d);
    end
    bus(1'b1, `EPC_IDX_TX_CFG, 8'h01, d);
    @(negedge ref_clk);
    chk("tx enable", 1'b1, tx_en);
    bus(1'b1, `EPC_IDX_TX_ADDR_CTRL, 8'h25, d);
    t_cmd = $realtime;
    bus(1'b1, `EPC_IDX_TX_ADDR_CTRL, 8'hA6, d);
    bus(1'b0, `EPC_IDX_TX_ADDR_CTRL, 8'h00, d);
    chk("tx cmd kept", 8'h25, d);
    idle(`EPC_IDX_TX_STAT, t_cmd);
    // Fill every indirect location, then read all back
    for (int s = 0; s < 32; s++) begin
      cfg[s] = {hi[s / 8], s[0], s[2:0]};
      trk[s] = 8'(s * 53) ^ 8'hA5;
      sig[s] = 8'(s * 27) | 8'hF0;
      d = cfg[s];
      ind(1'b1, 7'h20 + 7'(s), d);
      d = trk[s];
      ind(1'b1, 7'h40 + 7'(s), d);
      d = sig[s];
      if (s > 0) ind(1'b1, 7'h60 + 7'(s), d);
    end
    d = 8'h5A;
    ind(1'b1, 7'h00, d);
    ind(1'b1, 7'h60, d);
    for (int s = 0; s < 32; s++) begin
      ind(1'b0, 7'h20 + 7'(s), d);
      chk("cfg byte", cfg[s], d);
      ind(1'b0, 7'h40 + 7'(s), d);
      chk("trunk byte", trk[s], d);
      ind(1'b0, 7'h60 + 7'(s), d);
      chk("sig byte", s > 0 ? {4'h0, sig[s][3:0]} : 8'h00, d);
    end
    // Second command during a running read is dropped
    bus(1'b1, `EPC_IDX_RX_ADDR_CTRL, 8'hA1, d);
    t_cmd = $realtime;
    bus(1'b1, `EPC_IDX_RX_ADDR_CTRL, 8'hC5, d);
    bus(1'b0, `EPC_IDX_RX_ADDR_CTRL, 8'h00, d);
    chk("cmd kept", 8'hA1, d);
    idle(`EPC_IDX_RX_STAT, t_cmd);
    bus(1'b0, `EPC_IDX_RX_DATA_BUF, 8'h00, d);
    chk("busy read", cfg[1], d);
    phase(1'b0, 1'b0, 1'b0, 1'b0);
    phase(1'b1, 1'b0, 1'b0, 1'b0);
    phase(1'b1, 1'b1, 1'b1, 1'b1);
    wrap_up();
  end
endmodule // epc_rx_payload_ctrl_tb
